// ### hdl/osc_op_state_control.sv
/*
 * Operating-state controller of a sub-GHz receiver: function-enable
 * register, state command and status register, software reset.
 * Assumes a serial-port front end outside that turns host frames into
 * one-cycle register read and write strobes synchronous to clock_i.
 */
// Function
// - Bit 5 enables manufacturing test, resets 0
// - Bit 2 picks 400 kHz or 1 MHz
// - Bits 7:5 report current operating state
// - Successful power-up ends in sleep state
// - Failed power-on reset stays in power-up
// - No command reaches the power-up state
// - One-hot command codes switch operating state
// - Other command values are ignored
// - Writing 0xff at 0x4f resets device
// - Other soft-reset values do nothing
// - Software reset reruns power-up, then sleep
// - Bit 6 halts the sleep timer
`timescale 1ns/1ps

module osc_op_state_control (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic por_ok_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    output logic [2:0] current_state_o,
    output logic manufacturing_test_enable_o,
    output logic fast_serial_port_enable_o,
    output logic sleep_timer_halt_o,
    output logic soft_reset_o
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire logic hit_function_enable = reg_addr_i == osc_pkg::ADDR_FUNCTION_ENABLE;
    wire logic hit_state_control = reg_addr_i == osc_pkg::ADDR_OPERATING_STATE_CONTROL;
    wire logic hit_software_reset = reg_addr_i == osc_pkg::ADDR_SOFTWARE_RESET;
    wire logic write_function_enable = reg_write_i && hit_function_enable;
    wire logic write_state_control = reg_write_i && hit_state_control;
    // Only the exact key fires; anything else falls through silently
    wire logic soft_reset_hit = reg_write_i && hit_software_reset
        && (reg_wdata_i == osc_pkg::SOFT_RESET_KEY);
    // A taken key restarts the state, timer, enable and command registers; the registered outputs restart on the reset pin only
    wire logic soft_reset_take = ce_i && soft_reset_hit;
    wire logic restart = !rst_b_i || soft_reset_take;

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    osc_pkg::osc_state_t state;
    osc_pkg::osc_state_t next_state;
    logic [7:0] function_enable;
    logic [4:0] state_command_field;
    logic command_pending;
    logic [7:0] power_up_count;
    logic [2:0] current_state_field;
    logic [7:0] next_rdata;

    // ----------------------------------------------------------------
    // Power-up timer decode
    // ----------------------------------------------------------------
    // The timer stalls while the power-on check is bad, so a supply
    // that never settles leaves the block parked in power-up
    wire logic power_up_done = power_up_count == osc_pkg::POWER_UP_LAST;
    wire logic power_up_step = state == osc_pkg::OSC_POWER_UP && por_ok_i && !power_up_done;

    // ----------------------------------------------------------------
    // Status code
    // ----------------------------------------------------------------
    // Status code of the present state
    always_comb
    begin
        case (state)
            osc_pkg::OSC_POWER_UP: current_state_field = osc_pkg::CODE_POWER_UP;
            osc_pkg::OSC_SLEEP: current_state_field = osc_pkg::CODE_SLEEP;
            osc_pkg::OSC_STANDBY: current_state_field = osc_pkg::CODE_STANDBY;
            osc_pkg::OSC_TUNE: current_state_field = osc_pkg::CODE_TUNE;
            osc_pkg::OSC_RECEIVE: current_state_field = osc_pkg::CODE_RECEIVE;
            osc_pkg::OSC_NVM: current_state_field = osc_pkg::CODE_NVM;
            default: current_state_field = osc_pkg::CODE_POWER_UP;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Next operating state; power-up is entered only through reset
    always_comb
    begin
        next_state = state;
        if (state == osc_pkg::OSC_POWER_UP)
        begin
            // Held here for as long as the power-on check fails
            if (por_ok_i && power_up_done)
                next_state = osc_pkg::OSC_SLEEP;
        end
        else if (command_pending)
        begin
            case (state_command_field)
                osc_pkg::CMD_GO_NVM: next_state = osc_pkg::OSC_NVM;
                osc_pkg::CMD_GO_STANDBY: next_state = osc_pkg::OSC_STANDBY;
                osc_pkg::CMD_GO_TUNE: next_state = osc_pkg::OSC_TUNE;
                osc_pkg::CMD_GO_RECEIVE: next_state = osc_pkg::OSC_RECEIVE;
                osc_pkg::CMD_GO_SLEEP: next_state = osc_pkg::OSC_SLEEP;
                default: next_state = state;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    // Reserved and write-only locations read zero; the key register
    // must never echo the key back to the host
    wire logic [7:0] control_readback = {current_state_field, state_command_field};
    assign next_rdata = hit_function_enable ? function_enable
        : (hit_state_control ? control_readback : 8'h00);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // State machine and power-up timer
    always_ff @(posedge clock_i)
    begin
        if (restart)
        begin
            // Soft reset takes the same path as power-on reset
            state <= osc_pkg::OSC_POWER_UP;
            power_up_count <= 8'h00;
        end
        else if (ce_i)
        begin
            state <= next_state;
            if (power_up_step)
                power_up_count <= power_up_count + 8'h01;
        end
    end

    // Function enable register; reserved bits are stored as written
    always_ff @(posedge clock_i)
    begin
        if (restart)
            function_enable <= osc_pkg::FUNCTION_ENABLE_RESET;
        else if (ce_i && write_function_enable)
            function_enable <= reg_wdata_i;
    end

    // Command field; a write arms one transition, acting clears it
    always_ff @(posedge clock_i)
    begin
        if (restart)
        begin
            state_command_field <= osc_pkg::STATE_COMMAND_RESET;
            command_pending <= 1'b0;
        end
        else if (ce_i)
        begin
            if (write_state_control)
            begin
                state_command_field <= reg_wdata_i[4:0];
                command_pending <= 1'b1;
            end
            else if (state != osc_pkg::OSC_POWER_UP)
                command_pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Read data holds until the next read strobe; a soft reset leaves it
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 8'h00;
        else if (ce_i && reg_read_i)
            reg_rdata_o <= next_rdata;
    end

    // Status lags the state by one cycle so it leaves a flip-flop
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            current_state_o <= osc_pkg::CODE_POWER_UP;
        else if (ce_i)
            current_state_o <= current_state_field;
    end

    // Enable levels follow the stored register bits
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            manufacturing_test_enable_o <= 1'b0;
            fast_serial_port_enable_o <= 1'b0;
            sleep_timer_halt_o <= 1'b0;
        end
        else if (ce_i)
        begin
            manufacturing_test_enable_o <= function_enable[osc_pkg::BIT_MANUFACTURING_TEST_ENABLE];
            fast_serial_port_enable_o <= function_enable[osc_pkg::BIT_FAST_SERIAL_PORT_ENABLE];
            sleep_timer_halt_o <= function_enable[osc_pkg::BIT_SLEEP_TIMER_HALT];
        end
    end

    // One-cycle pulse per accepted key, for the rest of the chip
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            soft_reset_o <= 1'b0;
        else if (ce_i)
            soft_reset_o <= soft_reset_hit;
    end

endmodule // osc_op_state_control

// ### inc/osc_pkg.sv
/*
 * Constants for the operating-state controller: register offsets,
 * field positions, reset values, state codes, commands and timing.
 * Assumes a 125 MHz system clock.
 */
package osc_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_FUNCTION_ENABLE = 7'h46;
    localparam logic [6:0] ADDR_OPERATING_STATE_CONTROL = 7'h47;
    localparam logic [6:0] ADDR_SOFTWARE_RESET = 7'h4f;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int BIT_SLEEP_TIMER_HALT = 6;
    localparam int BIT_MANUFACTURING_TEST_ENABLE = 5;
    localparam int BIT_FAST_SERIAL_PORT_ENABLE = 2;
    localparam logic [7:0] FUNCTION_ENABLE_RESET = 8'h00;
    localparam logic [4:0] STATE_COMMAND_RESET = 5'h00;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hff;

    // Commands written to the state command field
    localparam logic [4:0] CMD_GO_NVM = 5'h01;
    localparam logic [4:0] CMD_GO_STANDBY = 5'h02;
    localparam logic [4:0] CMD_GO_TUNE = 5'h04;
    localparam logic [4:0] CMD_GO_RECEIVE = 5'h08;
    localparam logic [4:0] CMD_GO_SLEEP = 5'h10;

    // Codes shown in the current state field
    localparam logic [2:0] CODE_POWER_UP = 3'h0;
    localparam logic [2:0] CODE_SLEEP = 3'h1;
    localparam logic [2:0] CODE_STANDBY = 3'h2;
    localparam logic [2:0] CODE_TUNE = 3'h3;
    localparam logic [2:0] CODE_RECEIVE = 3'h4;
    localparam logic [2:0] CODE_NVM = 3'h5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ = 125;
    localparam int POWER_UP_TIME_NS = 1000;
    localparam int POWER_UP_CYCLES = (POWER_UP_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [7:0] POWER_UP_LAST = 8'(POWER_UP_CYCLES - 1);

    // Operating states
    typedef enum logic [2:0] {
        OSC_POWER_UP,
        OSC_SLEEP,
        OSC_STANDBY,
        OSC_TUNE,
        OSC_RECEIVE,
        OSC_NVM
    } osc_state_t;

endpackage

// ### verification/osc_op_state_control_asserts.sv
/* Port checker for the operating-state controller.
   Assumes it is bound to the design; reset is synchronous, active low. */
`timescale 1ns/1ps
module osc_op_state_control_asserts (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic por_ok_i,
    input wire logic reg_write_i,
    input wire logic soft_reset_o,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [2:0] current_state_o,
    input wire logic manufacturing_test_enable_o,
    input wire logic fast_serial_port_enable_o,
    input wire logic sleep_timer_halt_o
);
    // Taken writes; nothing is taken while ce_i is low
    wire logic wr = reg_write_i && ce_i;
    wire logic kill = wr && reg_addr_i == 7'h4f && reg_wdata_i == 8'hff;
    wire logic [2:0] st = current_state_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    srst_pulse_a: assert property (kill |=> soft_reset_o)
        else $error("no reset pulse");
    srst_ignore_a: assert property (soft_reset_o |-> $past(kill))
        else $error("stray reset pulse");
    srst_state_a: assert property (soft_reset_o |=> st == 3'h0)
        else $error("no power-up");
    no_boot_cmd_a: assert property (st == 3'h0 && $past(st) != 3'h0 |-> $past(soft_reset_o))
        else $error("power-up by command");
    boot_hold_a: assert property ((st == 3'h0 && !por_ok_i) [*3] |=> st == 3'h0)
        else $error("left power-up");
    boot_sleep_a: assert property ($past(st) == 3'h0 && st != 3'h0 |-> st == 3'h1)
        else $error("not sleep");
    fe_bits_a: assert property (wr && reg_addr_i == 7'h46 ##1 ce_i |=>
        {sleep_timer_halt_o, manufacturing_test_enable_o, fast_serial_port_enable_o} ==
        $past({reg_wdata_i[6:5], reg_wdata_i[2]}, 2)) else $error("enable bits");
    cmd_go_a: assert property (wr && reg_addr_i == 7'h47 && reg_wdata_i[4:0] == 5'h02 && st != 3'h0
        && !soft_reset_o ##1 (ce_i && !reg_write_i) [*2] |=> st == 3'h2) else $error("no standby");
endmodule // osc_op_state_control_asserts
bind osc_op_state_control osc_op_state_control_asserts osc_op_state_control_asserts_inst (.*);

// ### verification/osc_host.sv
/* Host model driving the register strobe port.
   Assumes strobes are sampled on the rising clock_i. */
`timescale 1ns/1ps
module osc_host #(parameter int HOLD_OFF = 200) (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [6:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_write_o,
    output logic reg_read_o
);
    // Idle strobes from time zero
    initial
    begin
        reg_write_o = 1'b0;
        reg_read_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 8'h00;
    end
    // One write; released lines show the inverse, not the last value
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_wdata_o <= (a == 7'h46) ? (d & 8'h64) : d;
        reg_write_o <= 1'b1;
        @(posedge clock_i);
        reg_write_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
        // Hold-off shortened from 10 ms to keep the run short
        if (a == 7'h4f && d == 8'hff) repeat (HOLD_OFF) @(posedge clock_i);
    endtask
    // One read; data stands from the strobe edge on and is taken at the next edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_read_o <= 1'b1;
        @(posedge clock_i);
        reg_read_o <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge clock_i);
        d = reg_rdata_i;
    endtask
endmodule // osc_host

// ### verification/osc_op_state_control_test.sv
/* Self-checking bench: host model on the register port.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module osc_op_state_control_test;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic por_ok_i = 1'b0;
    logic reg_write_i, reg_read_i, manufacturing_test_enable_o, fast_serial_port_enable_o, sleep_timer_halt_o;
    logic soft_reset_o;
    logic [6:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, d;
    logic [2:0] current_state_o;
    wire logic [7:0] fe = {5'h0, sleep_timer_halt_o, manufacturing_test_enable_o, fast_serial_port_enable_o};
    int n_errors = 0;
    int samples_checked = 0;
    int n_boot_cycles = 0;
    int n_soft_pulses = 0;
    osc_op_state_control osc_op_state_control_inst (.*);
    osc_host osc_host_inst (.clock_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_write_o(reg_write_i), .reg_read_o(reg_read_i));
    initial forever #4 clock_i = ~clock_i;
    // Power-up status cycles and reset pulses, counted for the reset checks
    always @(posedge clock_i)
    begin
        if (current_state_o === 3'h0)
            n_boot_cycles <= n_boot_cycles + 1;
        if (soft_reset_o === 1'b1)
            n_soft_pulses <= n_soft_pulses + 1;
    end
    // ----------------------------------------------------------------
    // Compare, report and finish
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
        osc_host_inst.rd(a, d);
        check(d, exp);
    endtask
    task automatic tally_and_finish();
        $display("%0d compared, %0d mismatches", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Power-up stalls while the check is bad, then lands in sleep
    task automatic t_power_up();
        int i;
        repeat (200) @(posedge clock_i);
        check(8'(current_state_o), 8'h00);
        por_ok_i <= 1'b1;
        for (i = 0; i < 300 && current_state_o !== 3'h1; i++)
            @(posedge clock_i);
        check(8'(i == 300), 8'h00);
        rd_check(7'h47, 8'h20);
        $display("power-up test done");
    endtask
    // Every command, then codes that must be ignored
    task automatic t_commands();
        logic [4:0] cmd [9] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h03, 5'h11, 5'h1f};
        logic [2:0] code [9] = '{3'h5, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
        for (int k = 0; k < 9; k++)
        begin
            osc_host_inst.wr(7'h47, {3'h7, cmd[k]});
            repeat (2) @(posedge clock_i);
            rd_check(7'h47, {code[k], cmd[k]});
        end
        $display("command test done");
    endtask
    // Enable bits, then a wrong key, a read-back and the real key
    task automatic t_enable_and_reset();
        int pulses;
        int boots;
        osc_host_inst.wr(7'h46, 8'hff);
        repeat (2) @(posedge clock_i);
        check(fe, 8'h07);
        rd_check(7'h46, 8'h64);
        osc_host_inst.wr(7'h47, 8'h08);
        pulses = n_soft_pulses;
        osc_host_inst.wr(7'h4f, 8'hfe);
        repeat (4) @(posedge clock_i);
        check({current_state_o, fe[4:0]}, 8'h87);
        check(8'(n_soft_pulses - pulses), 8'h00);
        rd_check(7'h4f, 8'h00);
        rd_check(7'h12, 8'h00);
        boots = n_boot_cycles;
        osc_host_inst.wr(7'h4f, 8'hff);
        check(8'(n_soft_pulses - pulses), 8'h01);
        check(8'(n_boot_cycles - boots), 8'(osc_pkg::POWER_UP_CYCLES));
        check({current_state_o, fe[4:0]}, 8'h20);
        rd_check(7'h47, 8'h20);
        $display("enable and reset test done");
    endtask
    // Frozen clock enable: a write is not taken and nothing moves
    task automatic t_clock_enable();
        @(posedge clock_i);
        ce_i <= 1'b0;
        osc_host_inst.wr(7'h47, 8'h02);
        repeat (3) @(posedge clock_i);
        check(8'(current_state_o), 8'h01);
        ce_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd_check(7'h47, 8'h20);
        $display("clock enable test done");
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_power_up();
        if (n_errors == 0)
        begin
            t_commands();
            t_enable_and_reset();
            t_clock_enable();
        end
        tally_and_finish();
    end
endmodule // osc_op_state_control_test
